// ### rtl/dac_pkg.sv
// Package for the dual converter status and mode control block.
// Assumes an 8-bit special function register bus inside the core.
package dac_pkg;

   // Register addresses on the special function register bus
   localparam logic [7:0] MODE_ADDR = 8'hd1;  // Mode register
   localparam logic [7:0] STAT_ADDR = 8'hd8;  // Status register, bit addressable

   // Values after reset
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;

   // Mode register fields
   localparam int MODE_PRI_EN_BIT = 5;
   localparam int MODE_AUX_EN_BIT = 4;
   localparam int MODE_FLD_LSB    = 0;
   localparam logic [7:0] MODE_WMASK = 8'h37;  // Writable bits

   // Status register fields
   localparam int STAT_PRI_RDY_BIT = 7;
   localparam int STAT_AUX_RDY_BIT = 6;
   localparam int STAT_CAL_BIT     = 5;
   localparam int STAT_NOREF_BIT   = 4;
   localparam int STAT_PRI_ERR_BIT = 3;
   localparam int STAT_AUX_ERR_BIT = 2;

   // Result width of each converter
   localparam int RES_W = 16;
   localparam logic [15:0] RES_ONES = 16'hffff;
   localparam logic [15:0] RES_ZERO = 16'h0000;

   // Operating modes
   typedef enum logic [2:0] {
      MD_PDOWN  = 3'b000,
      MD_IDLE   = 3'b001,
      MD_SINGLE = 3'b010,
      MD_CONT   = 3'b011,
      MD_ZS_INT = 3'b100,
      MD_FS_INT = 3'b101,
      MD_ZS_SYS = 3'b110,
      MD_FS_SYS = 3'b111
   } dac_mode_t;

   // Register bus request
   typedef struct packed {
      logic       rd;      // Byte read strobe
      logic       wr;      // Byte write strobe
      logic       bit_wr;  // Single bit write strobe
      logic [7:0] addr;    // Register address
      logic [2:0] bit_sel; // Bit select for bit writes
      logic [7:0] wdata;   // Byte data, bit 0 carries the bit value
   } dac_bus_req_t;

   // Event report from one converter core
   typedef struct packed {
      logic             done;      // Conversion or calibration finished
      logic             cal;       // Finished cycle was a calibration
      logic             cal_fail;  // Calibration could not update coefficients
      logic             use_xref;  // Converter runs on the external reference
      logic [RES_W-1:0] raw;       // Unclamped result
      logic             ovr;       // Raw result over range
      logic             und;       // Raw result under range
   } dac_conv_evt_t;

   // Control from this block to one converter core
   typedef struct packed {
      logic      pwr_en;   // Converter powered
      logic      hold_rst; // Filter and modulator held in reset
      logic      clk_en;   // Modulator clocks running
      logic      restart;  // One-cycle reset pulse
      dac_mode_t mode;     // Mode seen by the converter
   } dac_conv_ctl_t;

endpackage

// ### rtl/dac_res_path.sv
// Result and coefficient write path of one converter.
// Assumes the converter core reports events as dac_conv_evt_t.
`timescale 1ns/1ps
module dac_res_path (
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   input  wire dac_pkg::dac_conv_evt_t evt_i,
   input  wire logic              rdy_i,     // Ready flag currently set
   input  wire logic              noref_i,   // Missing reference flag
   output logic                   res_we_o,  // Result register updated
   output logic                   cal_we_o,  // Coefficients updated
   output logic                   clamp_o,   // Stored result was clamped
   output logic [15:0]            result_o   // Stored result
);
   import dac_pkg::*;

   logic [15:0] result_q;  // Held result
   logic        conv_ok;    // Conversion may store
   logic        force_one;  // Reference missing, force full scale
   logic [15:0] clamped;    // Value after clamping
   logic        clip;       // Clamp happened

   // Stores are blocked while ready is still set
   assign conv_ok   = evt_i.done & ~evt_i.cal & ~rdy_i;               // RULE_03
   assign force_one = noref_i & evt_i.use_xref;                       // RULE_08
   assign clamped   = (force_one | evt_i.ovr) ? RES_ONES :
                      (evt_i.und ? RES_ZERO : evt_i.raw);
   assign clip      = force_one | evt_i.ovr | evt_i.und;
   assign res_we_o  = conv_ok;
   assign clamp_o   = conv_ok & clip;                                  // RULE_09
   assign cal_we_o  = evt_i.done & evt_i.cal & ~evt_i.cal_fail & ~rdy_i; // RULE_03
   assign result_o  = result_q;

   // Result register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         result_q <= RES_ZERO;
      end else if (ce_i && conv_ok) begin
         result_q <= clamped;
      end
   end
endmodule

// ### rtl/dac_conv_ctl.sv
// Per-converter control decode: power, reset hold and restart.
// Assumes mode and enable come from the mode register.
`timescale 1ns/1ps
module dac_conv_ctl (
   input  wire logic               en_i,      // Converter enable bit
   input  wire dac_pkg::dac_mode_t mode_i,    // Operating mode field
   input  wire logic               restart_i, // Mode field written
   output dac_pkg::dac_conv_ctl_t  ctl_o
);
   import dac_pkg::*;

   logic active;  // Enabled and not powered down
   assign active = en_i & (mode_i != MD_PDOWN);                 // RULE_13
   assign ctl_o.pwr_en   = active;
   assign ctl_o.hold_rst = ~active | (mode_i == MD_IDLE);       // RULE_16
   assign ctl_o.clk_en   = active;                              // RULE_16
   assign ctl_o.restart  = restart_i;                           // RULE_20
   assign ctl_o.mode     = active ? mode_i : MD_PDOWN;          // RULE_15
endmodule

// ### rtl/dac_ctrl.sv
// Status and mode control for a primary and an auxiliary converter.
// Assumes a byte-wide register bus with read and write strobes and
// a bit-write strobe for the bit addressable status register.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Primary done sets status bit 7
// RULE_02 - Primary ready cleared by software or mode write; code clears it only on single, continuous or calibration mode writes
// RULE_03 - Ready set blocks result and coefficient writes
// RULE_04 - Bit 6 is auxiliary ready, same behaviour
// RULE_05 - Any calibration finish sets bit 5
// RULE_06 - Calibration flag cleared only by mode write
// RULE_07 - Bit 4 shows bad reference while active
// RULE_08 - Bad external reference forces result ones
// RULE_09 - Clamped primary result sets bit 3
// RULE_10 - Failed calibration also sets primary error
// RULE_11 - Mode write clears primary error; code clears it only on single, continuous or calibration mode writes
// RULE_12 - Bit 2 is auxiliary error, same behaviour
// RULE_13 - Mode bit 5 enables primary converter
// RULE_14 - Mode bit 4 enables auxiliary converter
// RULE_15 - Mode field zero is power-down, default
// RULE_16 - Idle holds filter reset, clocks run
// RULE_17 - Single mode converts exactly once
// RULE_18 - Single done stores, then field returns zero
// RULE_19 - Continuous mode keeps updating results
// RULE_20 - Any mode field write resets both
// RULE_21 - Calibration write clears ready, ends at zero
// RULE_22 - Reserved bits ignore writes, read zero
module dac_ctrl (
   input  wire logic                   clk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   ce_i,         // Clock enable, freezes state
   input  wire dac_pkg::dac_bus_req_t  bus_i,        // Register bus request
   output logic [7:0]                  rdata_o,      // Read data
   output logic                        rsel_o,       // Address hits a register
   input  wire dac_pkg::dac_conv_evt_t pri_evt_i,    // Primary converter events
   input  wire dac_pkg::dac_conv_evt_t aux_evt_i,    // Auxiliary converter events
   input  wire logic                   ref_bad_i,    // Reference detector output
   output dac_pkg::dac_conv_ctl_t      pri_ctl_o,    // Primary converter control
   output dac_pkg::dac_conv_ctl_t      aux_ctl_o,    // Auxiliary converter control
   output logic [15:0]                 pri_result_o, // Primary result
   output logic [15:0]                 aux_result_o, // Auxiliary result
   output logic                        pri_cal_we_o, // Primary coefficient write
   output logic                        aux_cal_we_o  // Auxiliary coefficient write
);
   import dac_pkg::*;

   // Decode of one address hit with a strobe
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target,
                                input logic strobe);
      hit = strobe & (a == target);
   endfunction

   logic [7:0] mode_q;       // Mode register
   logic [7:0] mode_d;
   logic [5:0] stat_q;       // Status bits 7..2 (bit 0 here is status bit 2)
   logic [5:0] stat_d;
   logic [1:0] pend_q;       // Converters still owing a first result after a single, continuous or calibration start
   logic [1:0] pend_d;

   // Bus decode
   logic mode_wr;      // Byte write to mode register
   logic stat_wr;      // Byte write to status register
   logic stat_bwr;     // Bit write to status register
   logic mode_rd;
   logic stat_rd;
   assign mode_wr  = hit(bus_i.addr, MODE_ADDR, bus_i.wr);
   assign stat_wr  = hit(bus_i.addr, STAT_ADDR, bus_i.wr);
   assign stat_bwr = hit(bus_i.addr, STAT_ADDR, bus_i.bit_wr);
   assign mode_rd  = hit(bus_i.addr, MODE_ADDR, bus_i.rd);
   assign stat_rd  = hit(bus_i.addr, STAT_ADDR, bus_i.rd);
   assign rsel_o   = (bus_i.addr == MODE_ADDR) | (bus_i.addr == STAT_ADDR);

   // Mode write content
   dac_mode_t new_mode;
   logic      new_is_cal;
   logic      new_starts;   // Written code starts a conversion or calibration
   assign new_mode   = dac_mode_t'(bus_i.wdata[2:0]);
   assign new_is_cal = bus_i.wdata[2];
   assign new_starts = (new_mode == MD_SINGLE) | (new_mode == MD_CONT) | new_is_cal;

   // Current mode
   dac_mode_t cur_mode;
   logic      cur_is_cal;
   logic      pri_en;
   logic      aux_en;
   assign cur_mode   = dac_mode_t'(mode_q[2:0]);
   assign cur_is_cal = mode_q[2];
   assign pri_en     = mode_q[MODE_PRI_EN_BIT];                 // RULE_13
   assign aux_en     = mode_q[MODE_AUX_EN_BIT];                 // RULE_14

   // Converter control decode
   logic mode_rst;   // Any write to the mode field restarts both
   assign mode_rst = mode_wr & ce_i;                            // RULE_20

   dac_conv_ctl u_pri_ctl (
      .en_i      (pri_en),
      .mode_i    (cur_mode),
      .restart_i (mode_rst),
      .ctl_o     (pri_ctl_o)
   );

   dac_conv_ctl u_aux_ctl (
      .en_i      (aux_en),
      .mode_i    (cur_mode),
      .restart_i (mode_rst),
      .ctl_o     (aux_ctl_o)
   );

   // Reference flag only while a converter is active
   logic any_active;
   logic noref;
   assign any_active = (pri_en | aux_en) & (cur_mode != MD_PDOWN);
   assign noref      = ref_bad_i & any_active;                  // RULE_07

   // Events are ignored unless the converter runs in a converting mode
   logic runs;
   dac_conv_evt_t pri_evt;
   dac_conv_evt_t aux_evt;
   assign runs = (cur_mode == MD_SINGLE) | (cur_mode == MD_CONT) | cur_is_cal;
   always_comb begin
      pri_evt      = pri_evt_i;
      aux_evt      = aux_evt_i;
      // Single mode takes one result per converter
      pri_evt.done = pri_evt_i.done & pri_en & runs &
                     ((cur_mode != MD_SINGLE) | pend_q[0]);     // RULE_17
      aux_evt.done = aux_evt_i.done & aux_en & runs &
                     ((cur_mode != MD_SINGLE) | pend_q[1]);     // RULE_17
      pri_evt.cal  = cur_is_cal;
      aux_evt.cal  = cur_is_cal;
   end

   // Result paths
   logic pri_res_we;
   logic aux_res_we;
   logic pri_clamp;
   logic aux_clamp;

   dac_res_path u_pri_res (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .evt_i     (pri_evt),
      .rdy_i     (stat_q[5]),
      .noref_i   (noref),
      .res_we_o  (pri_res_we),
      .cal_we_o  (pri_cal_we_o),
      .clamp_o   (pri_clamp),
      .result_o  (pri_result_o)
   );

   dac_res_path u_aux_res (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .evt_i     (aux_evt),
      .rdy_i     (stat_q[4]),
      .noref_i   (noref),
      .res_we_o  (aux_res_we),
      .cal_we_o  (aux_cal_we_o),
      .clamp_o   (aux_clamp),
      .result_o  (aux_result_o)
   );

   // Cycle completion per converter
   logic pri_fin;
   logic aux_fin;
   logic pri_cal_err;
   logic aux_cal_err;
   assign pri_fin     = pri_evt.done & ~stat_q[5];
   assign aux_fin     = aux_evt.done & ~stat_q[4];
   assign pri_cal_err = pri_fin & cur_is_cal & pri_evt_i.cal_fail;  // RULE_10
   assign aux_cal_err = aux_fin & cur_is_cal & aux_evt_i.cal_fail;  // RULE_12

   // Pending single, continuous or calibration work after this cycle
   logic [1:0] pend_left;
   assign pend_left = pend_q & ~{aux_fin, pri_fin};
   assign pend_d    = mode_wr ? ({bus_i.wdata[MODE_AUX_EN_BIT], bus_i.wdata[MODE_PRI_EN_BIT]}
                                 & {2{new_starts}})
                              : pend_left;

   // Mode register next value
   logic one_shot;   // Current mode finishes by returning to power-down
   assign one_shot = (cur_mode == MD_SINGLE) | cur_is_cal;
   always_comb begin
      mode_d = mode_q;
      if (mode_wr) begin
         mode_d = bus_i.wdata & MODE_WMASK;                     // RULE_22
      end else if (one_shot && (pend_q != 2'b00) && (pend_left == 2'b00)) begin
         mode_d[2:0] = MD_PDOWN;                                // RULE_18 RULE_21
      end
   end

   // Status next value: software clears, then hardware sets win
   logic [5:0] sw_clr;   // Bits cleared by software or mode write
   logic [5:0] hw_set;   // Bits set by hardware this cycle
   always_comb begin
      sw_clr = 6'h00;
      if (stat_wr) begin
         // Only ready bits are writable; writing zero clears
         sw_clr[5] = ~bus_i.wdata[STAT_PRI_RDY_BIT];            // RULE_02
         sw_clr[4] = ~bus_i.wdata[STAT_AUX_RDY_BIT];            // RULE_04
      end
      if (stat_bwr && !bus_i.wdata[0]) begin
         sw_clr[5] = (bus_i.bit_sel == 3'(STAT_PRI_RDY_BIT));   // RULE_02
         sw_clr[4] = (bus_i.bit_sel == 3'(STAT_AUX_RDY_BIT));   // RULE_04
      end
      if (mode_wr && (new_starts || new_is_cal)) begin
         sw_clr[5] = 1'b1;                                      // RULE_02 RULE_21
         sw_clr[4] = 1'b1;                                      // RULE_04 RULE_21
         sw_clr[3] = 1'b1;                                      // RULE_06
         sw_clr[1] = 1'b1;                                      // RULE_11
         sw_clr[0] = 1'b1;                                      // RULE_12
      end
      hw_set    = 6'h00;
      hw_set[5] = pri_fin;                                      // RULE_01
      hw_set[4] = aux_fin;                                      // RULE_04
      hw_set[3] = (pri_fin | aux_fin) & cur_is_cal;             // RULE_05
      hw_set[1] = (pri_res_we & pri_clamp) | pri_cal_err;       // RULE_09 RULE_10
      hw_set[0] = (aux_res_we & aux_clamp) | aux_cal_err;       // RULE_12
      stat_d    = (stat_q & ~sw_clr) | hw_set;
      stat_d[2] = 1'b0;   // Reference flag is live, not stored
   end

   // Register state
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_q <= MODE_RST;                                    // RULE_15
         stat_q <= STAT_RST[7:2];
         pend_q <= 2'b00;
      end else if (ce_i) begin
         mode_q <= mode_d;                                      // RULE_19
         stat_q <= stat_d;
         pend_q <= pend_d;
      end
   end

   // Read data, reserved bits read zero
   logic [7:0] stat_view;
   assign stat_view = {stat_q[5:3], noref, stat_q[1:0], 2'b00}; // RULE_07 RULE_22
   assign rdata_o   = mode_rd ? mode_q : (stat_rd ? stat_view : 8'h00);
endmodule

// ### bench/dac_ctrl_properties.sv
// Concurrent checks on the ports of the converter status and mode block.
// Assumes it is bound to dac_ctrl and sees its ports only.
`timescale 1ns/1ps
module dac_ctrl_properties
   import dac_pkg::*;
(
   input wire logic          clk_i,
   input wire logic          sys_rst_i,
   input wire logic          ce_i,
   input wire dac_bus_req_t  bus_i,
   input wire logic [7:0]    rdata_o,
   input wire logic          rsel_o,
   input wire dac_conv_evt_t pri_evt_i,
   input wire dac_conv_ctl_t pri_ctl_o,
   input wire dac_conv_ctl_t aux_ctl_o,
   input wire logic [15:0]   pri_result_o,
   input wire logic          pri_cal_we_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Mode byte write taken this cycle
   wire mode_wr = bus_i.wr && ce_i && bus_i.addr == MODE_ADDR;
   chk_mode_restart: assert property (
      mode_wr |-> pri_ctl_o.restart && aux_ctl_o.restart) else $error("restart missing");
   chk_mode_field: assert property (
      mode_wr && bus_i.wdata[5] |=> pri_ctl_o.mode == $past(bus_i.wdata[2:0]))
      else $error("mode field not taken");
   chk_pri_off: assert property (
      mode_wr && !bus_i.wdata[5] |=> !pri_ctl_o.pwr_en) else $error("primary not off");
   chk_aux_off: assert property (
      mode_wr && !bus_i.wdata[4] |=> !aux_ctl_o.pwr_en) else $error("aux not off");
   chk_idle_hold: assert property (
      pri_ctl_o.pwr_en && pri_ctl_o.mode == MD_IDLE |-> pri_ctl_o.hold_rst && pri_ctl_o.clk_en)
      else $error("idle hold wrong");
   chk_stat_reserved: assert property (
      bus_i.rd && bus_i.addr == STAT_ADDR |-> rdata_o[1:0] == 2'b00 && rsel_o)
      else $error("status reserved bits set");
   chk_mode_reserved: assert property (
      bus_i.rd && bus_i.addr == MODE_ADDR |-> (rdata_o & ~MODE_WMASK) == 8'h00)
      else $error("mode reserved bits set");
   chk_result_hold: assert property (
      !pri_evt_i.done |=> $stable(pri_result_o)) else $error("result moved without event");
   chk_single_return: assert property (
      ce_i && !bus_i.wr && pri_evt_i.done && pri_ctl_o.pwr_en && !aux_ctl_o.pwr_en
      && pri_ctl_o.mode == MD_SINGLE |=> pri_ctl_o.mode == MD_PDOWN)
      else $error("single did not end");
   chk_cal_cause: assert property (
      pri_cal_we_o |-> pri_evt_i.done && !pri_evt_i.cal_fail && pri_ctl_o.mode[2])
      else $error("coefficient write without cause");
   cov_single: cover property (pri_evt_i.done && pri_ctl_o.mode == MD_SINGLE);
   cov_cal: cover property (pri_cal_we_o);
   cov_idle: cover property (pri_ctl_o.pwr_en && pri_ctl_o.mode == MD_IDLE);
endmodule
bind dac_ctrl dac_ctrl_properties chk_i (.clk_i, .sys_rst_i, .ce_i, .bus_i, .rdata_o,
   .rsel_o, .pri_evt_i, .pri_ctl_o, .aux_ctl_o, .pri_result_o, .pri_cal_we_o);

// ### bench/test_dac_ctrl.sv
// Self-checking bench for the converter status and mode block.
// Assumes dac_pkg and dac_ctrl are compiled first.
`timescale 1ns/1ps
module test_dac_ctrl;
   import dac_pkg::*;
   logic          clk_i = 1'b0;
   logic          sys_rst_i = 1'b1;
   logic          ce_i = 1'b1;
   logic          ref_bad_i = 1'b0;
   dac_bus_req_t  bus_i = '0;
   dac_conv_evt_t pri_evt = '0;
   dac_conv_evt_t aux_evt = '0;
   dac_conv_ctl_t pri_ctl;
   dac_conv_ctl_t aux_ctl;
   logic [7:0]    rdata;
   logic          rsel;
   logic [15:0]   pri_res;
   logic [15:0]   aux_res;
   logic          pri_cwe;
   logic          aux_cwe;
   logic          pcw;
   logic          acw;
   int            n_fail = 0;
   int            num_checks = 0;
   int            cyc = 0;
   // Rows: mode byte written, readback, primary power, aux power
   localparam logic [17:0] ROWS [6] = '{{8'h21, 8'h21, 2'b10}, {8'h12, 8'h12, 2'b01},
      {8'hff, 8'h37, 2'b11}, {8'h30, 8'h30, 2'b00}, {8'h0b, 8'h03, 2'b00},
      {8'h35, 8'h35, 2'b11}};

   dac_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i),
      .rdata_o(rdata), .rsel_o(rsel), .pri_evt_i(pri_evt), .aux_evt_i(aux_evt),
      .ref_bad_i(ref_bad_i), .pri_ctl_o(pri_ctl), .aux_ctl_o(aux_ctl),
      .pri_result_o(pri_res), .aux_result_o(aux_res), .pri_cal_we_o(pri_cwe),
      .aux_cal_we_o(aux_cwe));

   // Clock of 50 ns
   always #25 clk_i = ~clk_i;

   // Hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Byte write, one strobe cycle then idle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= {3'b010, a, 3'h0, d};
      @(posedge clk_i);
      bus_i <= '0;
   endtask

   // Single bit write to the status register
   task automatic bw(input logic [2:0] s, input logic v);
      @(posedge clk_i);
      bus_i <= {3'b001, STAT_ADDR, s, 7'h00, v};
      @(posedge clk_i);
      bus_i <= '0;
   endtask

   // Byte read, data compared while the strobe stands
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk_i);
      bus_i <= {3'b100, a, 11'h000};
      #10 chk(nm, rdata, exp);
      @(posedge clk_i);
      bus_i <= '0;
   endtask

   // Event with flags cal, cal_fail, use_xref, ovr, und
   function automatic dac_conv_evt_t mk(input logic [15:0] r, input logic [4:0] f);
      return {1'b1, f[4:2], r, f[1:0]};
   endfunction

   // One-cycle done pulse, coefficient strobes captured mid-cycle
   task automatic ev(input logic a, input dac_conv_evt_t e);
      @(posedge clk_i);
      if (a) aux_evt <= e;
      else pri_evt <= e;
      #10;
      pcw = pri_cwe;
      acw = aux_cwe;
      @(posedge clk_i);
      pri_evt <= '0;
      aux_evt <= '0;
      #10;
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(MODE_ADDR, MODE_RST, "mode reset");
      rd(STAT_ADDR, STAT_RST, "status reset");
      rd(8'hd2, 8'h00, "unmapped read");
      foreach (ROWS[i]) begin
         wr(MODE_ADDR, ROWS[i][17:10]);
         rd(MODE_ADDR, ROWS[i][9:2], "mode readback");
         chk("primary power", pri_ctl.pwr_en, ROWS[i][1]);
         chk("aux power", aux_ctl.pwr_en, ROWS[i][0]);
      end
      // Single conversion on the primary
      wr(MODE_ADDR, 8'h22);
      ev(0, mk(16'h1234, 5'h00));
      chk("single result", pri_res, 16'h1234);
      rd(STAT_ADDR, 8'h80, "ready after single");
      rd(MODE_ADDR, 8'h20, "field after single");
      // Continuous, second result held off while ready stands
      wr(MODE_ADDR, 8'h23);
      ev(0, mk(16'h5a5a, 5'h00));
      ev(0, mk(16'h0f0f, 5'h00));
      chk("held result", pri_res, 16'h5a5a);
      bw(3'd7, 1'b0);
      rd(STAT_ADDR, 8'h00, "bit clear ready");
      ev(0, mk(16'h0f0f, 5'h00));
      chk("next result", pri_res, 16'h0f0f);
      // Clamping to ones and zeros
      wr(STAT_ADDR, 8'h00);
      ev(0, mk(16'h1111, 5'h02));
      chk("over clamp", pri_res, RES_ONES);
      rd(STAT_ADDR, 8'h88, "error after clamp");
      wr(STAT_ADDR, 8'h00);
      ev(0, mk(16'h2222, 5'h01));
      chk("under clamp", pri_res, RES_ZERO);
      wr(MODE_ADDR, 8'h23);
      rd(STAT_ADDR, 8'h00, "mode write clears");
      // Missing reference while active
      @(posedge clk_i) ref_bad_i <= 1'b1;
      rd(STAT_ADDR, 8'h10, "reference flag");
      ev(0, mk(16'h1111, 5'h04));
      chk("reference clamp", pri_res, RES_ONES);
      rd(STAT_ADDR, 8'h98, "reference error");
      wr(MODE_ADDR, 8'h03);
      rd(STAT_ADDR, 8'h00, "reference inactive");
      @(posedge clk_i) ref_bad_i <= 1'b0;
      // Auxiliary overflow, result moves away from its reset value
      wr(MODE_ADDR, 8'h13);
      ev(1, mk(16'h3333, 5'h02));
      chk("aux clamp", aux_res, RES_ONES);
      rd(STAT_ADDR, 8'h44, "aux ready and error");
      // Calibration on both, the auxiliary one fails
      wr(MODE_ADDR, 8'h34);
      rd(STAT_ADDR, 8'h00, "cal start clears");
      ev(0, mk(16'h0000, 5'h10));
      chk("pri coefficient write", pcw, 1'b1);
      ev(1, mk(16'h0000, 5'h18));
      chk("aux coefficient write", acw, 1'b0);
      rd(STAT_ADDR, 8'he4, "cal flags");
      rd(MODE_ADDR, 8'h30, "field after cal");
      wr(MODE_ADDR, 8'h31);
      rd(STAT_ADDR, 8'he4, "idle keeps flags");
      wr(STAT_ADDR, 8'h00);
      rd(STAT_ADDR, 8'h24, "cal survives clear");
      wr(MODE_ADDR, 8'h02);
      rd(STAT_ADDR, 8'h00, "start clears all");
      // Clock enable low: a mode write is not taken
      ce_i <= 1'b0;
      wr(MODE_ADDR, 8'h23);
      ce_i <= 1'b1;
      rd(MODE_ADDR, 8'h02, "frozen by enable");
      // Reset in mid-run returns the mode register and both results to defaults
      wr(MODE_ADDR, 8'h21);
      @(posedge clk_i) sys_rst_i <= 1'b1;
      @(posedge clk_i) sys_rst_i <= 1'b0;
      chk("primary result after reset", pri_res, RES_ZERO);
      chk("aux result after reset", aux_res, RES_ZERO);
      rd(MODE_ADDR, MODE_RST, "mode after reset");
      tally_and_finish();
   end
endmodule
